// file: core/lrr_params.svh
// Offsets, field positions, reset values and timing counts of the logger RTC
`ifndef LRR_PARAMS_SVH
`define LRR_PARAMS_SVH

`define LRR_ADDR_SECONDS     16'h0200
`define LRR_ADDR_MINUTES     16'h0201
`define LRR_ADDR_HOURS       16'h0202
`define LRR_ADDR_DATE        16'h0203
`define LRR_ADDR_MONTH       16'h0204
`define LRR_ADDR_YEAR        16'h0205
`define LRR_ADDR_RATE_LOW    16'h0206
`define LRR_ADDR_RATE_HIGH   16'h0207
`define LRR_ADDR_TEMP_LOW    16'h0208
`define LRR_ADDR_TEMP_HIGH   16'h0209
`define LRR_ADDR_HUMID_LOW   16'h020a
`define LRR_ADDR_HUMID_HIGH  16'h020b
`define LRR_ADDR_TRES_LOW    16'h020c
`define LRR_ADDR_TRES_HIGH   16'h020d
`define LRR_ADDR_HRES_LOW    16'h020e
`define LRR_ADDR_HRES_HIGH   16'h020f
`define LRR_ADDR_TEMP_EN     16'h0210
`define LRR_ADDR_HUMID_EN    16'h0211
`define LRR_ADDR_RTC_CTL     16'h0212

// Writable bits of each byte; the rest read zero, except the humidity enable upper bits, which read ones
`define LRR_MASK_SECONDS     8'h7f
`define LRR_MASK_MINUTES     8'h7f
`define LRR_MASK_HOURS       8'h7f
`define LRR_MASK_DATE        8'h3f
`define LRR_MASK_MONTH       8'h9f
`define LRR_MASK_RATE_HIGH   8'h3f
`define LRR_MASK_CTL2        8'h03
`define LRR_HUMID_EN_ONES    6'h3f

`define LRR_HOUR_MODE_BIT    6
`define LRR_HOUR_PM_BIT      5
`define LRR_CENTURY_FLAG_BIT         7
`define LRR_UNIT_SEC_BIT     1
`define LRR_OSC_BIT          0
`define LRR_HIGH_EN_BIT      1
`define LRR_LOW_EN_BIT       0

`define LRR_RST_DATE         8'h01
`define LRR_RST_MONTH        8'h01
`define LRR_TEMP_OVER_WIDE   16'hffe0
`define LRR_TEMP_OVER_NARROW 16'hff00

`define LRR_ALM_TEMP_LOW     0
`define LRR_ALM_TEMP_HIGH    1
`define LRR_ALM_HUMID_LOW    2
`define LRR_ALM_HUMID_HIGH   3

`define LRR_SECOND_NS        1000000000
`define LRR_CLK_PERIOD_NS    5

`endif

// file: core/lrr_pkg.sv
// Types shared by the logger RTC and result logic
package lrr_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } lrr_reg_req_s;

  typedef struct packed {
    logic        valid;
    logic        humid;
    logic        under;
    logic        over;
    logic [15:0] raw;
  } lrr_conv_s;

  typedef struct packed {
    logic        valid;
    logic        humid;
    logic        wide;
    logic [15:0] data;
  } lrr_log_s;

endpackage : lrr_pkg

// file: core/lrr_rtc_regs.sv
// Logger register page: BCD clock, sample rate, results, thresholds
//
// Contract
// - Fixed-zero clock bits read zero, ignore writes
// - Time fields held as tens/units BCD digits
// - Hours bit 6 selects 12-hour mode
// - Bit 5 is PM, or twenty-hours digit
// - Century bit writable, toggles on 99 to 00
// - February 29 when year divisible by four
// - Sample interval counted in seconds or minutes
// - Sample rate 14 bits, top bits zero
// - Sample rate zero behaves as one
// - No writes accepted during a mission
// - Temperature low byte keeps three bits only
// - Out-of-range temperature gives zeros, or ones in the kept bits only
// - Temperature codes unsigned, half or sixteenth degrees
// - Latest temperature matches logged sample encoding
// - Temperature alarm compares high byte only
// - Humidity always taken as full sixteen bits
// - Humidity MSB at high byte bit 7
// - Humidity low byte logged in both widths, marked by wide
// - Humidity alarm compares raw high byte only
// - Enabled temperature high alarm sets temperature high flag
// - Control bit 1 selects seconds sample unit
`timescale 1ns/100ps
`default_nettype none
`include "lrr_params.svh"
module lrr_rtc_regs
  import lrr_pkg::*;
#(
  parameter int TICK_CYCLES = `LRR_SECOND_NS / `LRR_CLK_PERIOD_NS
)(
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_ce,
  input  wire lrr_reg_req_s i_req,
  input  wire lrr_conv_s    i_conv,
  input  wire logic         i_mission_active,
  input  wire logic         i_temp_log_wide,
  input  wire logic         i_humid_log_wide,
  output logic [7:0]        o_rd_data,
  output logic              o_rd_valid,
  output lrr_log_s          o_log,
  output logic [3:0]        o_alarm_set,
  output logic              o_sample_due
);

  ////////////////////////////////////////////////////////////////////////////
  // BCD helpers

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    else
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc

  // 10 is 2 modulo 4, so only the tens LSB matters
  function automatic logic is_leap(input logic [7:0] y);
    logic [3:0] s;
    s = {2'h0, y[4], 1'b0} + y[3:0];
    is_leap = (s[1:0] == 2'h0);
  endfunction : is_leap

  function automatic logic [7:0] month_days(input logic [4:0] m,
                                            input logic [7:0] y);
    unique case (m)
      5'h02:                      month_days = is_leap(y) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
      default:                    month_days = 8'h31;
    endcase
  endfunction : month_days

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  clock_seconds;
  logic [7:0]  clock_minutes;
  logic [7:0]  clock_hours;
  logic [7:0]  calendar_date;
  logic [7:0]  calendar_month;
  logic [7:0]  calendar_year;
  logic [7:0]  sample_interval_low;
  logic [7:0]  sample_interval_high;
  logic [7:0]  temp_low_threshold;
  logic [7:0]  temp_high_threshold;
  logic [7:0]  humid_low_threshold;
  logic [7:0]  humid_high_threshold;
  logic [15:0] temp_result;
  logic [15:0] humid_result;
  logic [1:0]  temp_alarm_en;
  logic [1:0]  humid_alarm_en;
  logic [1:0]  rtc_ctl;
  logic [31:0] presc;
  logic        sec_tick;
  logic        host_wr;
  logic        time_wr;
  logic        adv;
  logic        day_carry;
  logic        month_carry;
  logic        year_carry;
  logic [7:0]  next_seconds;
  logic [7:0]  next_minutes;
  logic [7:0]  next_hours;
  logic [7:0]  next_date;
  logic [7:0]  next_month;
  logic [7:0]  next_year;
  logic [7:0]  rd_mux;
  logic [15:0] temp_code;
  logic        sample_unit_seconds;
  logic        osc_on;

  assign sample_unit_seconds = rtc_ctl[`LRR_UNIT_SEC_BIT];
  assign osc_on  = rtc_ctl[`LRR_OSC_BIT];
  assign host_wr = i_req.wr && !i_mission_active;
  assign time_wr = host_wr && i_req.addr >= `LRR_ADDR_SECONDS
                   && i_req.addr <= `LRR_ADDR_YEAR;
  // A host write to the time bytes takes this tick's place
  assign adv     = sec_tick && osc_on && !time_wr;

  ////////////////////////////////////////////////////////////////////////////
  // One-second time base

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      presc    <= '0;
      sec_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      sec_tick <= 1'b0;
      if (!osc_on)
        presc <= '0;
      else if (presc == 32'(TICK_CYCLES - 1))
      begin
        presc    <= '0;
        sec_tick <= 1'b1;
      end
      else
        presc <= presc + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calendar next state

  always_comb
  begin
    logic [7:0] hinc;
    hinc         = bcd_inc({3'h0, clock_hours[4:0]});
    next_seconds = clock_seconds;
    next_minutes = clock_minutes;
    next_hours   = clock_hours;
    next_date    = calendar_date;
    next_month   = calendar_month;
    next_year    = calendar_year;
    day_carry    = 1'b0;
    month_carry  = 1'b0;
    year_carry   = 1'b0;
    if (adv && clock_seconds == 8'h59 && clock_minutes == 8'h59)
    begin
      if (clock_hours[`LRR_HOUR_MODE_BIT])
      begin
        if (clock_hours[4:0] == 5'h12)
          next_hours = {clock_hours[7:5], 5'h01};
        else
        begin
          next_hours = {clock_hours[7:5], hinc[4:0]};
          if (clock_hours[4:0] == 5'h11)
          begin
            next_hours[`LRR_HOUR_PM_BIT] = ~clock_hours[`LRR_HOUR_PM_BIT];
            day_carry = clock_hours[`LRR_HOUR_PM_BIT];
          end
        end
      end
      else if (clock_hours[5:0] == 6'h23)
      begin
        next_hours = {clock_hours[7:6], 6'h00};
        day_carry  = 1'b1;
      end
      else
        next_hours = {clock_hours[7:6], 6'(bcd_inc({2'h0, clock_hours[5:0]}))};
    end
    if (adv)
    begin
      next_seconds = (clock_seconds == 8'h59) ? 8'h00
                     : bcd_inc(clock_seconds);
      if (clock_seconds == 8'h59)
        next_minutes = (clock_minutes == 8'h59) ? 8'h00
                       : bcd_inc(clock_minutes);
    end
    if (day_carry)
    begin
      month_carry = (calendar_date
                     == month_days(calendar_month[4:0], calendar_year));
      next_date   = month_carry ? `LRR_RST_DATE : bcd_inc(calendar_date);
    end
    if (month_carry)
    begin
      year_carry = (calendar_month[4:0] == 5'h12);
      next_month = {calendar_month[7:5], year_carry ? 5'h01
                    : 5'(bcd_inc({3'h0, calendar_month[4:0]}))};
    end
    if (year_carry)
    begin
      next_year = (calendar_year == 8'h99) ? 8'h00 : bcd_inc(calendar_year);
      if (calendar_year == 8'h99)
        next_month[`LRR_CENTURY_FLAG_BIT] = ~calendar_month[`LRR_CENTURY_FLAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock and calendar bytes

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clock_seconds  <= 8'h00;
      clock_minutes  <= 8'h00;
      clock_hours    <= 8'h00;
      calendar_date  <= `LRR_RST_DATE;
      calendar_month <= `LRR_RST_MONTH;
      calendar_year  <= 8'h00;
    end
    else if (i_ce)
    begin
      clock_seconds  <= next_seconds;
      clock_minutes  <= next_minutes;
      clock_hours    <= next_hours;
      calendar_date  <= next_date;
      calendar_month <= next_month;
      calendar_year  <= next_year;
      if (time_wr)
      begin
        unique case (i_req.addr)
          `LRR_ADDR_SECONDS:
            clock_seconds  <= i_req.wdata & `LRR_MASK_SECONDS;
          `LRR_ADDR_MINUTES:
            clock_minutes  <= i_req.wdata & `LRR_MASK_MINUTES;
          `LRR_ADDR_HOURS:
            clock_hours    <= i_req.wdata & `LRR_MASK_HOURS;
          `LRR_ADDR_DATE:
            calendar_date  <= i_req.wdata & `LRR_MASK_DATE;
          `LRR_ADDR_MONTH:
            calendar_month <= i_req.wdata & `LRR_MASK_MONTH;
          default:
            calendar_year  <= i_req.wdata;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate, thresholds and control bytes

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sample_interval_low  <= 8'h00;
      sample_interval_high <= 8'h00;
      temp_low_threshold   <= 8'h00;
      temp_high_threshold  <= 8'h00;
      humid_low_threshold  <= 8'h00;
      humid_high_threshold <= 8'h00;
      temp_alarm_en        <= 2'h0;
      humid_alarm_en       <= 2'h0;
      rtc_ctl              <= 2'h0;
    end
    else if (i_ce)
    begin
      if (i_mission_active)
        rtc_ctl[`LRR_OSC_BIT] <= 1'b1;
      if (host_wr)
      begin
        case (i_req.addr)
          `LRR_ADDR_RATE_LOW:   sample_interval_low  <= i_req.wdata;
          `LRR_ADDR_RATE_HIGH:
            sample_interval_high <= i_req.wdata & `LRR_MASK_RATE_HIGH;
          `LRR_ADDR_TEMP_LOW:   temp_low_threshold   <= i_req.wdata;
          `LRR_ADDR_TEMP_HIGH:  temp_high_threshold  <= i_req.wdata;
          `LRR_ADDR_HUMID_LOW:  humid_low_threshold  <= i_req.wdata;
          `LRR_ADDR_HUMID_HIGH: humid_high_threshold <= i_req.wdata;
          `LRR_ADDR_TEMP_EN:    temp_alarm_en        <= i_req.wdata[1:0];
          `LRR_ADDR_HUMID_EN:   humid_alarm_en       <= i_req.wdata[1:0];
          `LRR_ADDR_RTC_CTL:    rtc_ctl              <= i_req.wdata[1:0];
          default:              ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion results, log strobe and alarm events

  always_comb
  begin
    if (i_conv.under)
      temp_code = 16'h0000;
    else if (i_conv.over)
      temp_code = i_temp_log_wide ? `LRR_TEMP_OVER_WIDE
                                  : `LRR_TEMP_OVER_NARROW;
    else
      temp_code = {i_conv.raw[15:8],
                   i_temp_log_wide ? {i_conv.raw[7:5], 5'h00} : 8'h00};
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      temp_result  <= 16'h0000;
      humid_result <= 16'h0000;
      o_log        <= '0;
      o_alarm_set  <= 4'h0;
    end
    else if (i_ce)
    begin
      o_log       <= '0;
      o_alarm_set <= 4'h0;
      if (i_conv.valid && !i_conv.humid)
      begin
        temp_result <= temp_code;
        o_log <= '{valid: i_mission_active, humid: 1'b0,
                   wide: i_temp_log_wide, data: temp_code};
        if (i_mission_active)
        begin
          o_alarm_set[`LRR_ALM_TEMP_HIGH] <= temp_alarm_en[`LRR_HIGH_EN_BIT]
            && temp_code[15:8] >= temp_high_threshold;
          o_alarm_set[`LRR_ALM_TEMP_LOW] <= temp_alarm_en[`LRR_LOW_EN_BIT]
            && temp_code[15:8] <= temp_low_threshold;
        end
      end
      if (i_conv.valid && i_conv.humid)
      begin
        humid_result <= i_conv.raw;
        o_log <= '{valid: i_mission_active, humid: 1'b1,
                   wide: i_humid_log_wide, data: i_conv.raw};
        if (i_mission_active)
        begin
          o_alarm_set[`LRR_ALM_HUMID_HIGH] <= humid_alarm_en[`LRR_HIGH_EN_BIT]
            && i_conv.raw[15:8] >= humid_high_threshold;
          o_alarm_set[`LRR_ALM_HUMID_LOW] <= humid_alarm_en[`LRR_LOW_EN_BIT]
            && i_conv.raw[15:8] <= humid_low_threshold;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb
  begin
    case (i_req.addr)
      `LRR_ADDR_SECONDS:    rd_mux = clock_seconds;
      `LRR_ADDR_MINUTES:    rd_mux = clock_minutes;
      `LRR_ADDR_HOURS:      rd_mux = clock_hours;
      `LRR_ADDR_DATE:       rd_mux = calendar_date;
      `LRR_ADDR_MONTH:      rd_mux = calendar_month;
      `LRR_ADDR_YEAR:       rd_mux = calendar_year;
      `LRR_ADDR_RATE_LOW:   rd_mux = sample_interval_low;
      `LRR_ADDR_RATE_HIGH:  rd_mux = sample_interval_high;
      `LRR_ADDR_TEMP_LOW:   rd_mux = temp_low_threshold;
      `LRR_ADDR_TEMP_HIGH:  rd_mux = temp_high_threshold;
      `LRR_ADDR_HUMID_LOW:  rd_mux = humid_low_threshold;
      `LRR_ADDR_HUMID_HIGH: rd_mux = humid_high_threshold;
      `LRR_ADDR_TRES_LOW:   rd_mux = temp_result[7:0];
      `LRR_ADDR_TRES_HIGH:  rd_mux = temp_result[15:8];
      `LRR_ADDR_HRES_LOW:   rd_mux = humid_result[7:0];
      `LRR_ADDR_HRES_HIGH:  rd_mux = humid_result[15:8];
      `LRR_ADDR_TEMP_EN:    rd_mux = {6'h00, temp_alarm_en};
      `LRR_ADDR_HUMID_EN:   rd_mux = {`LRR_HUMID_EN_ONES, humid_alarm_en};
      `LRR_ADDR_RTC_CTL:    rd_mux = {6'h00, rtc_ctl};
      default:              rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      o_rd_valid <= i_req.rd;
      if (i_req.rd)
        o_rd_data <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample-interval counter

  lrr_sample_timer #(
    .RATE_W (14)
  ) u_sample_timer (
    .i_clk          (i_clk),
    .i_arst_n       (i_arst_n),
    .i_ce           (i_ce),
    .i_sec_tick     (adv),
    .i_min_tick     (adv && clock_seconds == 8'h59),
    .i_unit_seconds (sample_unit_seconds),
    .i_rate         ({sample_interval_high[5:0], sample_interval_low}),
    .i_run          (i_mission_active),
    .o_due          (o_sample_due)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_zero_bits_clear: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    !clock_seconds[7] && !clock_minutes[7] && !clock_hours[7]
    && calendar_date[7:6] == 2'h0 && calendar_month[6:5] == 2'h0)
    else $error("fixed-zero clock bit is set");

  a_rate_top_zero: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    sample_interval_high[7:6] == 2'h0)
    else $error("sample rate top bits not zero");

  a_mission_locked: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_mission_active && i_req.wr
    && i_req.addr == `LRR_ADDR_RATE_LOW |=> $stable(sample_interval_low))
    else $error("sample rate written during mission");

  a_pm_flip: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && adv && clock_hours[6] && clock_hours[4:0] == 5'h11
    && clock_minutes == 8'h59 && clock_seconds == 8'h59
    |=> clock_hours[4:0] == 5'h12 && clock_hours[5] != $past(clock_hours[5]))
    else $error("12-hour PM bit did not flip at twelve");

  a_century_wrap: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && year_carry && calendar_year == 8'h99
    |=> calendar_year == 8'h00
        && calendar_month[7] != $past(calendar_month[7]))
    else $error("century bit did not toggle on year wrap");

  a_leap_day: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && day_carry && calendar_month[4:0] == 5'h02
    && calendar_date == 8'h28 && is_leap(calendar_year)
    |=> calendar_date == 8'h29)
    else $error("leap day not inserted");

  a_temp_over: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_conv.valid && !i_conv.humid && i_conv.over && !i_conv.under
    && i_temp_log_wide |=> temp_result == `LRR_TEMP_OVER_WIDE)
    else $error("wide over-range temperature code wrong");

  a_temp_high_alarm: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_mission_active && i_conv.valid && !i_conv.humid
    && temp_alarm_en[1] && temp_code[15:8] >= temp_high_threshold
    |=> o_alarm_set[`LRR_ALM_TEMP_HIGH])
    else $error("temperature high alarm not raised");

  a_humid_word: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_conv.valid && i_conv.humid
    |=> humid_result == $past(i_conv.raw) && o_log.humid
        && o_log.wide == $past(i_humid_log_wide))
    else $error("humidity word not captured whole");

endmodule : lrr_rtc_regs
`default_nettype wire

// file: core/lrr_sample_timer.sv
// Sample-interval counter in seconds or minutes
`timescale 1ns/100ps
`default_nettype none
module lrr_sample_timer
  import lrr_pkg::*;
#(
  parameter int RATE_W = 14
)(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_ce,
  input  wire logic              i_sec_tick,
  input  wire logic              i_min_tick,
  input  wire logic              i_unit_seconds,
  input  wire logic [RATE_W-1:0] i_rate,
  input  wire logic              i_run,
  output logic                   o_due
);

  logic [RATE_W-1:0] count;
  logic [RATE_W-1:0] eff_rate;
  logic              unit_tick;

  assign eff_rate  = (i_rate == '0) ? RATE_W'(1) : i_rate;
  assign unit_tick = i_unit_seconds ? i_sec_tick : i_min_tick;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count <= '0;
      o_due <= 1'b0;
    end
    else if (i_ce)
    begin
      o_due <= 1'b0;
      if (!i_run)
        count <= '0;
      else if (unit_tick)
      begin
        if (count + RATE_W'(1) >= eff_rate)
        begin
          count <= '0;
          o_due <= 1'b1;
        end
        else
          count <= count + RATE_W'(1);
      end
    end
  end

  a_zero_as_one: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_run && i_rate == '0 && unit_tick |=> o_due)
    else $error("zero sample rate did not log every unit");

  a_due_unit: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    o_due |-> $past(unit_tick) && $past(i_run))
    else $error("sample due without a unit tick");

endmodule : lrr_sample_timer
`default_nettype wire

// file: dv/lrr_host.sv
// Host-side register master for the logger register page
`timescale 1ns/100ps
`default_nettype none
module lrr_host
  import lrr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output lrr_reg_req_s    o_req
);
  initial o_req = '0;
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= {1'b1, 1'b0, a, d};
    @(posedge i_clk);
    o_req <= '0;
  endtask : wr
  // One byte per read; time bytes are read in ascending order
  task rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk);
    o_req <= '0;
    @(posedge i_clk);
    d = i_rd_data;
    v = i_rd_valid;
  endtask : rd
endmodule : lrr_host
`default_nettype wire

// file: dv/lrr_rtc_regs_tb.sv
// Self-checking bench for the logger register page
`timescale 1ns/100ps
`default_nettype none
module lrr_rtc_regs_tb;
  import lrr_pkg::*;
  logic         clk, arst_n, mission, wide, rvalid, due, v;
  logic [7:0]   rdata, d;
  logic [3:0]   alm;
  lrr_reg_req_s req;
  lrr_conv_s    conv;
  lrr_log_s     lg;
  int           n_fail, checked, cyc, seed, r, n;
  logic [7:0]   mdl[12];
  logic [7:0]   msk[12] = '{8'h7f, 8'h7f, 8'h7f, 8'h3f, 8'h9f, 8'hff,
                            8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0]   tm[12] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99,
                           8'h59, 8'h59, 8'h71, 8'h28, 8'h02, 8'h04};
  logic [7:0]   ex[12] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h81, 8'h00,
                           8'h00, 8'h00, 8'h52, 8'h29, 8'h02, 8'h04};
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  lrr_host i_host (.i_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid),
                   .o_req(req));
  lrr_rtc_regs #(.TICK_CYCLES(100)) i_dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_ce(1'b1), .i_req(req), .i_conv(conv), .i_mission_active(mission),
    .i_temp_log_wide(wide), .i_humid_log_wide(wide), .o_rd_data(rdata),
    .o_rd_valid(rvalid), .o_log(lg), .o_alarm_set(alm),
    .o_sample_due(due));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rc(input logic [15:0] a, input logic [7:0] e);
    i_host.rd(a, d, v);
    chk({7'h00, v, d}, {8'h01, e});
  endtask : rc
  task cv(input logic [2:0] f, input logic [15:0] raw);
    @(posedge clk);
    conv <= {1'b1, f, raw};
    @(posedge clk);
    conv <= '0;
    @(posedge clk);
  endtask : cv
  // Load one time set, let exactly one second tick pass, stop the clock
  task run_clk(input int p);
    for (int i = 0; i < 6; i++)
      i_host.wr(16'h0200 + 16'(i), tm[p+i]);
    i_host.wr(16'h0212, 8'h01);
    repeat (150) @(posedge clk);
    i_host.wr(16'h0212, 8'h02);
  endtask : run_clk
  task results;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results;
    end
  end
  initial
  begin
    seed = 42;
    arst_n = 0;
    mission = 0;
    wide = 1;
    conv = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1;
    for (int i = 0; i < 12; i++)
    begin
      r = $random(seed);
      i_host.wr(16'h0200 + 16'(i), r[7:0]);
      mdl[i] = r[7:0] & msk[i];
    end
    for (int i = 0; i < 12; i++)
      rc(16'h0200 + 16'(i), mdl[i]);
    $display("done: registers");
    run_clk(0);
    for (int i = 0; i < 6; i++)
      rc(16'h0200 + 16'(i), ex[i]);
    run_clk(6);
    for (int i = 0; i < 6; i++)
      rc(16'h0200 + 16'(i), ex[i+6]);
    $display("done: calendar");
    i_host.wr(16'h0206, 8'h00);
    i_host.wr(16'h0207, 8'h00);
    i_host.wr(16'h0210, 8'h03);
    i_host.wr(16'h0209, 8'h85);
    i_host.wr(16'h0208, 8'h3e);
    i_host.wr(16'h0211, 8'h03);
    i_host.wr(16'h020a, 8'h58);
    i_host.wr(16'h020b, 8'h97);
    mission <= 1;
    i_host.wr(16'h0208, 8'h00);
    rc(16'h0208, 8'h3e);
    cv(3'b000, 16'h857f);
    chk(lg.data, 16'h8560);
    chk({12'h000, alm}, 16'h0002);
    rc(16'h020c, 8'h60);
    wide <= 0;
    cv(3'b001, 16'h1234);
    chk(lg.data, 16'hff00);
    cv(3'b010, 16'h1234);
    chk({lg.data, 12'h000, alm}, 32'h00000001);
    cv(3'b100, 16'hb5c3);
    chk({lg.valid, lg.humid, lg.wide, lg.data}, 19'h6b5c3);
    chk({28'h0, alm}, 32'h8);
    rc(16'h020f, 8'hb5);
    $display("done: conversions");
    n = 0;
    repeat (300)
    begin
      @(posedge clk);
      n += int'(due);
    end
    chk(16'(n), 16'd3);
    $display("done: sample rate");
    results;
  end
endmodule : lrr_rtc_regs_tb
`default_nettype wire
